// ==== logic/genset_mode_sequencer.sv ====
/*
 * Operating-mode sequencer of a generator-set controller: stop, auto and
 * manual run modes, start/stop sequencing, contactor interlock and fuel
 * pulse counting. Assumes pins arrive asynchronously and a plain register
 * port on the same clock; engine rate data is on the same clock.
 */
// The implementer's own choices: the plain strobed port and the address map.
//
// Contract
// - Fuel counter type 0 adds filling volume, type 1 adds consumption volume.
// - Fuel source 0 uses speed pulses for speed, 1 counts flowmeter pulses.
// - Pulses per volume unit (0..65000) convert pulses; unit litre or gallon.
// - Valid engine fuel rate is shown instead of pulse-derived consumption.
// - Stop mode stops the engine; still running after stop timer warns.
// - Stop mode ignores remote and force start until auto is selected.
// - Stop when loaded: ramp out, open genset contactor, cooldown; stop cuts.
// - Mains contactor closes only with mains in limits and phase order.
// - Transfer-switch stop clears remote start, opens genset contactor at once.
// - Sync auto: remote start runs, syncs, closes, shares; may stop or restart.
// - Transfer auto: mains fail asserts remote start; return swaps contactors.
// - Panel lock blocks mode buttons but not navigation; the stop button still acts under lock.
// - Mains availability: limits, then simulate, force start, remote start.
// - Wait start delay after mains loss; mains return abandons start.
// - Start: fuel and preheat, then idle timer, then heating timer.
// - Crank up to set attempts each within crank timer; release on firing.
// - Genset contactor needs good alternator and the contactor delay.
// - Mains return: wait period, open genset, close mains after delay.
// - Cooldown, idle before end, then fuel off and stop solenoid pulse.
// - Schedule-disabled auto flashes auto indicator and acts as stop.
// - Manual run starts regardless of mains and runs unloaded.
// - Manual contactor buttons toggle; other one opens first with its delay.
`timescale 1ns/1ps
`default_nettype none
module genset_mode_sequencer #(
	parameter int TICK_CYCLES = genset_pkg::TICK_CYCLES_DEF
) (
	input  wire logic                     ref_clk,
	input  wire logic                     reset,
	input  wire genset_pkg::pins_t        pins,
	input  wire genset_pkg::engine_rate_t engine_rate,
	input  wire logic [7:0]               addr,
	input  wire logic [31:0]              wdata,
	input  wire logic                     we,
	input  wire logic                     re,
	output var  logic [31:0]              rdata,
	output var  genset_pkg::relays_t      relays
);
	import genset_pkg::*;
	localparam int TW = $clog2(TICK_CYCLES);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
	localparam int PW = $bits(pins_t);
	initial begin
		if (TICK_CYCLES < 2) $error("TICK_CYCLES must be at least 2");
	end
	logic [PW-1:0]       pin_clean;
	pins_t               p;
	pins_t               p_prev_q;
	pins_t               rise;
	logic [TW-1:0]       tick_cnt_q;
	logic                tick_q;
	logic [CTRL_W-1:0]   ctrl_q;
	logic [15:0]         ppv_q;
	logic [15:0]         tcfg_q [N_TMR];
	logic [3:0]          attempts_q;
	mode_t               mode_q;
	logic                man_armed_q;
	state_t              state_q;
	state_t              state_d;
	logic [15:0]         tmr_q;
	logic [15:0]         tmr_load;
	logic [3:0]          tries_q;
	logic [15:0]         pcnt_q;
	logic [31:0]         fill_q;
	logic [31:0]         cons_q;
	logic [15:0]         cont_q;
	logic [15:0]         stop_cnt_q;
	logic [15:0]         blink_q;
	logic                blink_on_q;
	logic                man_gc_q;
	logic                man_mc_q;
	logic                running;
	logic                speed_seen_q;
	logic                speed_run_q;
	app_t                app;
	logic                eff_stop;
	logic                avail;
	logic                mains_permit;
	logic                demand;
	logic                tmr_done;
	logic                want_gc;
	logic                want_mc;
	logic                vol_evt;
	logic [3:0]          tidx;
	logic                tsel;
	pin_sync #(.W(PW)) u_sync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.raw     (pins),
		.clean   (pin_clean)
	);
	assign p    = pins_t'(pin_clean);
	assign rise = p & ~p_prev_q;
	assign app  = app_t'(ctrl_q[C_APP_LO +: 2]);
	always_ff @(posedge ref_clk) begin
		if (reset) p_prev_q <= '0;
		else       p_prev_q <= p;
	end
	// Millisecond tick keeps every timer at 16 bits
	always_ff @(posedge ref_clk) begin
		if (reset || tick_cnt_q == TICK_LAST) tick_cnt_q <= '0;
		else                                  tick_cnt_q <= tick_cnt_q + 1'b1;
		tick_q <= !reset && tick_cnt_q == TICK_LAST;
	end
	// Register writes
	assign tidx = 4'((addr - A_TMR_BASE) >> 2);
	assign tsel = addr >= A_TMR_BASE && addr < A_TMR_BASE + 8'(4 * N_TMR) && addr[1:0] == 2'h0;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl_q     <= CTRL_RST;
			ppv_q      <= PPV_RST;
			attempts_q <= ATTEMPTS_RST;
			for (int i = 0; i < N_TMR; i++) tcfg_q[i] <= TMR_RST[i];
		end else if (we) begin
			if (addr == A_CTRL) ctrl_q <= wdata[CTRL_W-1:0];
			if (addr == A_PPV) ppv_q <= (wdata > 32'(PPV_MAX)) ? PPV_MAX : wdata[15:0];
			if (addr == A_ATTEMPTS) attempts_q <= wdata[3:0];
			if (tsel) tcfg_q[tidx] <= wdata[15:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || !re) begin
			rdata <= '0;
		end else begin
			case (addr)
				A_CTRL:     rdata <= 32'(ctrl_q);
				A_PPV:      rdata <= 32'(ppv_q);
				A_ATTEMPTS: rdata <= 32'(attempts_q);
				A_STATUS: begin
					rdata <= '0;
					rdata[S_STATE_LO +: 4]              <= state_q;
					rdata[S_MODE_LO +: 2]               <= mode_q;
					rdata[S_RELAY_LO +: $bits(relays_t)] <= relays;
					rdata[S_AVAIL]                       <= avail;
				end
				A_FILL:     rdata <= fill_q;
				A_CONS:     rdata <= engine_rate.valid ? 32'(engine_rate.rate) : cons_q;
				default:    rdata <= tsel ? 32'(tcfg_q[tidx]) : 32'h0000_0000;
			endcase
		end
	end

	// Mode selection; stop press acts even under panel lock to end cooldown
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mode_q      <= MODE_STOP;
			man_armed_q <= 1'b0;
		end else if (rise.stop_btn) begin
			mode_q      <= MODE_STOP;
			man_armed_q <= 1'b0;
		end else if (!p.panel_lock) begin
			if (rise.auto_btn) mode_q <= MODE_AUTO;
			if (rise.manual_select_button) man_armed_q <= 1'b1;
			else if (rise.auto_btn) man_armed_q <= 1'b0;
			else if (rise.run_btn && man_armed_q) begin
				mode_q      <= MODE_RUN;
				man_armed_q <= 1'b0;
			end
		end
	end

	assign eff_stop = mode_q == MODE_STOP || (mode_q == MODE_AUTO && p.schedule_off);
	always_comb begin
		avail = p.mains_in_limits;
		if (p.simulate_mains) avail = 1'b1;
		if (p.force_start) avail = 1'b0;
		if (ctrl_q[C_RS_DEF]) avail = !p.remote_start_in;
	end

	assign mains_permit = p.mains_in_limits && (!ctrl_q[C_PHASE_CHK] || p.mains_phase_ok);
	// Stop mode never raises demand, whatever remote signals say
	always_comb begin
		demand = 1'b0;
		if (mode_q == MODE_RUN) demand = 1'b1;
		else if (!eff_stop && app == APP_SYNC) demand = p.remote_start_in;
		else if (!eff_stop) demand = !avail;
	end

	// Speed detection from pulses when the input is not used for fuel
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			speed_seen_q <= 1'b0;
			speed_run_q  <= 1'b0;
		end else if (tick_q) begin
			speed_seen_q <= rise.speed_pulse_input && !ctrl_q[C_FUEL_SRC];
			speed_run_q  <= speed_seen_q;
		end else if (rise.speed_pulse_input && !ctrl_q[C_FUEL_SRC]) begin
			speed_seen_q <= 1'b1;
		end
	end
	assign running  = p.engine_fired || speed_run_q;
	assign tmr_done = tmr_q == 16'h0000;
	always_comb begin
		state_d = state_q;
		case (state_q)
			S_REST:
				if (demand) state_d = (mode_q == MODE_RUN) ? S_PREHEAT : S_START_DLY;
			S_START_DLY:
				if (!demand) state_d = S_REST;
				else if (tmr_done) state_d = (app == APP_TRANSFER) ? S_LOADED : S_PREHEAT;
			S_PREHEAT:
				if (!demand) state_d = S_STOP_SOL;
				else if (tmr_done) state_d = S_CRANK;
			S_CRANK:
				if (running) state_d = S_IDLE;
				else if (!demand) state_d = S_REST;
				else if (tmr_done) state_d = (tries_q >= attempts_q) ? S_FAILED : S_CRANK_REST;
			S_CRANK_REST:
				if (!demand) state_d = S_REST;
				else if (tmr_done) state_d = S_CRANK;
			S_IDLE:
				if (!demand) state_d = S_STOP_SOL;
				else if (tmr_done) state_d = (mode_q == MODE_RUN) ? S_UNLOADED : S_HEAT;
			S_HEAT:
				if (!demand) state_d = S_COOL;
				else if (tmr_done) state_d = S_LOADED;
			S_LOADED:
				if (eff_stop && app == APP_TRANSFER) state_d = S_REST;
				else if (!demand && app == APP_SYNC) state_d = relays.genset_contactor ? S_RAMP : S_COOL;
				else if (eff_stop) state_d = S_COOL;
				else if (!demand) state_d = S_MAINS_WAIT;
				else if (mode_q == MODE_RUN) state_d = S_UNLOADED;
			S_RAMP:
				if (p.ramp_done) state_d = S_COOL;
				else if (demand) state_d = S_LOADED;
			S_MAINS_WAIT:
				if (demand) state_d = S_LOADED;
				else if (eff_stop || tmr_done) state_d = (app == APP_TRANSFER) ? S_REST : S_COOL;
			S_COOL:
				if (rise.stop_btn) state_d = S_STOP_SOL;
				else if (demand) state_d = (mode_q == MODE_RUN) ? S_UNLOADED : S_LOADED;
				else if (tmr_done) state_d = S_STOP_SOL;
			S_STOP_SOL:
				if (tmr_done) state_d = S_REST;
			S_FAILED:
				if (!demand) state_d = S_REST;
			S_UNLOADED:
				if (mode_q != MODE_RUN) state_d = (demand && !eff_stop) ? S_LOADED : S_COOL;
			default:
				state_d = S_REST;
		endcase
	end
	always_comb begin
		case (state_d)
			S_START_DLY:  tmr_load = tcfg_q[T_START];
			S_PREHEAT:    tmr_load = tcfg_q[T_PREHEAT];
			S_CRANK:      tmr_load = tcfg_q[T_CRANK];
			S_CRANK_REST: tmr_load = tcfg_q[T_CRANK];
			S_IDLE:       tmr_load = tcfg_q[T_IDLE];
			S_HEAT:       tmr_load = tcfg_q[T_HEAT];
			S_MAINS_WAIT: tmr_load = tcfg_q[T_MAINS_WAIT];
			S_COOL:       tmr_load = tcfg_q[T_COOL];
			S_STOP_SOL:   tmr_load = tcfg_q[T_STOP_SOL];
			default:      tmr_load = 16'h0000;
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= S_REST;
			tmr_q   <= 16'h0000;
		end else begin
			state_q <= state_d;
			if (state_d != state_q) tmr_q <= tmr_load;
			else if (tick_q && !tmr_done) tmr_q <= tmr_q - 1'b1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (reset || state_q == S_REST) tries_q <= 4'h0;
		else if (state_d == S_CRANK && state_q != S_CRANK) tries_q <= tries_q + 1'b1;
	end
	// Stop supervision: warning once the stop timer runs out with engine turning
	always_ff @(posedge ref_clk) begin
		if (reset || !eff_stop || !running || state_q != S_REST && state_q != S_STOP_SOL) begin
			stop_cnt_q <= 16'h0000;
		end else if (tick_q && stop_cnt_q != tcfg_q[T_STOP]) begin
			stop_cnt_q <= stop_cnt_q + 1'b1;
		end
	end
	// Manual contactor toggles; setting one clears the other's request
	always_ff @(posedge ref_clk) begin
		if (reset || mode_q != MODE_RUN) begin
			man_gc_q <= 1'b0;
			man_mc_q <= 1'b0;
		end else if (rise.genset_contactor_button) begin
			man_gc_q <= !man_gc_q;
			man_mc_q <= 1'b0;
		end else if (rise.mains_contactor_button) begin
			man_mc_q <= !man_mc_q;
			man_gc_q <= 1'b0;
		end
	end

	always_comb begin
		if (mode_q == MODE_RUN) begin
			want_gc = man_gc_q && p.gen_ok;
			want_mc = man_mc_q && mains_permit;
		end else begin
			want_gc = (state_q == S_LOADED || state_q == S_MAINS_WAIT || state_q == S_RAMP)
				&& p.gen_ok && (app != APP_SYNC || p.busbar_synced || relays.genset_contactor);
			want_mc = !want_gc && mains_permit && app != APP_SYNC;
		end
	end

	// Close only after the other is open and its delay has run out
	always_ff @(posedge ref_clk) begin
		if (reset || (!want_gc && !want_mc) || relays.genset_contactor || relays.mains_contactor) begin
			cont_q <= 16'h0000;
		end else if (tick_q && cont_q != 16'hFFFF) begin
			cont_q <= cont_q + 1'b1;
		end
	end
	// Fuel pulse scaling to volume units
	assign vol_evt = ctrl_q[C_FUEL_SRC] && rise.speed_pulse_input && ppv_q != 16'h0000 && pcnt_q == ppv_q - 1'b1;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pcnt_q <= 16'h0000;
			fill_q <= 32'h0000_0000;
			cons_q <= 32'h0000_0000;
		end else if (ctrl_q[C_FUEL_SRC] && rise.speed_pulse_input) begin
			pcnt_q <= vol_evt ? 16'h0000 : pcnt_q + 1'b1;
			if (vol_evt && !ctrl_q[C_FUEL_TYPE]) fill_q <= fill_q + 1'b1;
			if (vol_evt && ctrl_q[C_FUEL_TYPE]) cons_q <= cons_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || blink_q == 16'(BLINK_MS)) begin
			blink_q    <= 16'h0000;
			blink_on_q <= reset ? 1'b0 : !blink_on_q;
		end else if (tick_q) begin
			blink_q <= blink_q + 1'b1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			relays <= '0;
		end else begin
			relays.fuel          <= state_q inside {S_PREHEAT, S_CRANK, S_CRANK_REST, S_IDLE, S_HEAT, S_LOADED,
				S_RAMP, S_MAINS_WAIT, S_COOL, S_UNLOADED} && app != APP_TRANSFER;
			relays.preheat       <= state_q == S_PREHEAT;
			relays.crank         <= state_d == S_CRANK;
			relays.idle_speed    <= state_q == S_IDLE || (state_q == S_COOL && tmr_q <= tcfg_q[T_IDLE_LEAD]);
			relays.stop_solenoid <= state_q == S_STOP_SOL;
			relays.ramp_out_req  <= state_q == S_RAMP;
			relays.remote_start_out <= app == APP_TRANSFER && demand && mode_q != MODE_STOP;
			relays.auto_led      <= mode_q == MODE_AUTO && (!p.schedule_off || blink_on_q);
			relays.fail_to_stop  <= eff_stop && running && stop_cnt_q == tcfg_q[T_STOP];
			if (!want_gc) relays.genset_contactor <= 1'b0;
			else if (!relays.mains_contactor && cont_q >= tcfg_q[T_GEN_CONT]) relays.genset_contactor <= 1'b1;
			if (!want_mc) relays.mains_contactor <= 1'b0;
			else if (!relays.genset_contactor && cont_q >= tcfg_q[T_MAINS_CONT]) relays.mains_contactor <= 1'b1;
		end
	end
endmodule : genset_mode_sequencer
`default_nettype wire

// ==== logic/genset_pkg.sv ====
/*
 * Shared definitions of the genset mode sequencer: register map, field
 * positions, reset values, timing constants, modes, states and pin carriers.
 * Assumes a 50 MHz system clock and a 32-bit plain register port.
 */
package genset_pkg;

	localparam int CLK_NS          = 20;
	localparam int TICK_NS         = 1000000;
	localparam int TICK_CYCLES_DEF = TICK_NS / CLK_NS;
	localparam int BLINK_MS        = 500;

	localparam int AW = 8;
	localparam logic [AW-1:0] A_CTRL     = 8'h00;
	localparam logic [AW-1:0] A_PPV      = 8'h04;
	localparam logic [AW-1:0] A_TMR_BASE = 8'h08;
	localparam logic [AW-1:0] A_ATTEMPTS = 8'h38;
	localparam logic [AW-1:0] A_STATUS   = 8'h3C;
	localparam logic [AW-1:0] A_FILL     = 8'h40;
	localparam logic [AW-1:0] A_CONS     = 8'h44;

	localparam int C_FUEL_SRC  = 0;
	localparam int C_FUEL_TYPE = 1;
	localparam int C_GALLON    = 2;
	localparam int C_PHASE_CHK = 3;
	localparam int C_RS_DEF    = 4;
	localparam int C_APP_LO    = 5;
	localparam int CTRL_W      = 7;
	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

	localparam logic [15:0] PPV_MAX = 16'hFDE8;
	localparam logic [15:0] PPV_RST = 16'h03E8;
	localparam logic [3:0]  ATTEMPTS_RST = 4'h3;

	// Timer slots, all in milliseconds
	localparam int T_START      = 0;
	localparam int T_PREHEAT    = 1;
	localparam int T_CRANK      = 2;
	localparam int T_IDLE       = 3;
	localparam int T_HEAT       = 4;
	localparam int T_GEN_CONT   = 5;
	localparam int T_MAINS_WAIT = 6;
	localparam int T_MAINS_CONT = 7;
	localparam int T_COOL       = 8;
	localparam int T_IDLE_LEAD  = 9;
	localparam int T_STOP_SOL   = 10;
	localparam int T_STOP       = 11;
	localparam int N_TMR        = 12;
	localparam logic [15:0] TMR_RST [N_TMR] = '{
		16'h0BB8, 16'h0BB8, 16'h1770, 16'h2710, 16'h0BB8, 16'h03E8,
		16'h7530, 16'h03E8, 16'h7530, 16'h2710, 16'h2710, 16'h2710};

	localparam int S_STATE_LO = 0;
	localparam int S_MODE_LO  = 8;
	localparam int S_RELAY_LO = 16;
	localparam int S_AVAIL    = 31;

	typedef enum logic [1:0] {APP_MAINS_FAIL, APP_SYNC, APP_TRANSFER} app_t;
	typedef enum logic [1:0] {MODE_STOP, MODE_AUTO, MODE_RUN} mode_t;
	typedef enum logic [3:0] {
		S_REST, S_START_DLY, S_PREHEAT, S_CRANK, S_CRANK_REST, S_IDLE, S_HEAT,
		S_LOADED, S_RAMP, S_MAINS_WAIT, S_COOL, S_STOP_SOL, S_FAILED, S_UNLOADED
	} state_t;

	typedef struct packed {
		logic stop_btn;
		logic auto_btn;
		logic manual_select_button;
		logic run_btn;
		logic mains_contactor_button;
		logic genset_contactor_button;
		logic panel_lock;
		logic simulate_mains;
		logic force_start;
		logic remote_start_in;
		logic schedule_off;
		logic mains_in_limits;
		logic mains_phase_ok;
		logic gen_ok;
		logic engine_fired;
		logic busbar_synced;
		logic ramp_done;
		logic speed_pulse_input;
	} pins_t;

	typedef struct packed {
		logic fuel;
		logic preheat;
		logic crank;
		logic idle_speed;
		logic stop_solenoid;
		logic mains_contactor;
		logic genset_contactor;
		logic remote_start_out;
		logic ramp_out_req;
		logic auto_led;
		logic fail_to_stop;
	} relays_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] rate;
	} engine_rate_t;

endpackage : genset_pkg

// ==== logic/pin_sync.sv ====
/*
 * Three-stage synchroniser for a vector of pin inputs with agreement filter.
 * Assumes the pins are asynchronous to ref_clk; reset is synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] raw,
	output var  logic [W-1:0] clean
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	initial begin
		if (W < 1) $error("pin_sync width must be positive");
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accept a bit only once stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			clean <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) clean[i] <= s3_q[i];
			end
		end
	end
endmodule : pin_sync
`default_nettype wire

// ==== verif/engine_model.sv ====
/* Engine and alternator model behind the relays.
   Assumes relays are registered levels on ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module engine_model (
	input  wire logic                ref_clk,
	input  wire logic                reset,
	input  wire genset_pkg::relays_t relays,
	output var  logic                engine_fired,
	output var  logic                gen_ok,
	output var  logic                ramp_done,
	output var  logic                busbar_synced
);
	import genset_pkg::*;
	logic [2:0] crank_q;
	logic [2:0] warm_q;
	// Fires only after real cranking; fuel loss stops it at once
	always_ff @(posedge ref_clk) begin
		if (reset || !relays.fuel) begin
			crank_q <= 3'h0;
			engine_fired <= 1'b0;
		end else if (relays.crank) begin
			crank_q <= crank_q + 3'h1;
			if (crank_q == 3'h4) begin
				engine_fired <= 1'b1;
			end
		end
	end
	// Alternator settles a few cycles after firing
	always_ff @(posedge ref_clk) begin
		if (!engine_fired) begin
			warm_q <= 3'h0;
		end else if (warm_q != 3'h7) begin
			warm_q <= warm_q + 3'h1;
		end
	end
	always_ff @(posedge ref_clk) begin
		ramp_done <= relays.ramp_out_req;
	end
	assign gen_ok = warm_q > 3'h3;
	assign busbar_synced = gen_ok;
endmodule : engine_model
`default_nettype wire

// ==== verif/genset_mode_sequencer_sva.sv ====
/* Port checker for the genset mode sequencer.
   Assumes short timers and a well-behaved engine model from the bench. */
`timescale 1ns/1ps
`default_nettype none
module genset_mode_sequencer_sva #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic                     ref_clk,
	input wire logic                     reset,
	input wire genset_pkg::pins_t        pins,
	input wire genset_pkg::engine_rate_t engine_rate,
	input wire logic [7:0]               addr,
	input wire logic [31:0]              wdata,
	input wire logic                     we,
	input wire logic                     re,
	input wire logic [31:0]              rdata,
	input wire genset_pkg::relays_t      relays
);
	import genset_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence ppv_big_w;
		we && addr == A_PPV && wdata > 32'h0000FDE8;
	endsequence
	sequence ppv_rd;
		re && addr == A_PPV;
	endsequence
	contact_excl_a: assert property (!(relays.mains_contactor && relays.genset_contactor))
		else $error("both contactors closed");
	crank_fuel_a: assert property (relays.crank |-> relays.fuel && !relays.stop_solenoid)
		else $error("crank without fuel");
	preheat_fuel_a: assert property (relays.preheat |-> relays.fuel)
		else $error("preheat without fuel");
	solenoid_fuel_a: assert property (relays.stop_solenoid |-> !relays.fuel)
		else $error("stop solenoid with fuel on");
	crank_cut_a: assert property (pins.engine_fired [*8] |-> !relays.crank)
		else $error("crank held after firing");
	mains_ok_a: assert property ($rose(relays.mains_contactor) |->
		$past(pins.mains_in_limits, 4) || $past(pins.mains_in_limits, 5) || $past(pins.mains_in_limits, 6))
		else $error("mains contactor closed outside limits");
	gen_ok_a: assert property ($rose(relays.genset_contactor) |-> $past(pins.gen_ok, 5))
		else $error("genset contactor closed without good alternator");
	rdata_idle_a: assert property (!$past(re) |-> rdata == 32'h00000000)
		else $error("read data outside read slot");
	unmapped_rd_a: assert property (re && addr == 8'hFC |=> rdata == 32'h00000000)
		else $error("unmapped read not zero");
	ppv_clamp_a: assert property (ppv_big_w ##2 ppv_rd |=> rdata == 32'h0000FDE8)
		else $error("pulse setting not clamped");
	solenoid_c: cover property ($rose(relays.stop_solenoid));
endmodule : genset_mode_sequencer_sva
bind genset_mode_sequencer genset_mode_sequencer_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
	.ref_clk(ref_clk), .reset(reset), .pins(pins), .engine_rate(engine_rate), .addr(addr),
	.wdata(wdata), .we(we), .re(re), .rdata(rdata), .relays(relays));
`default_nettype wire

// ==== verif/testbench.sv ====
/* Self-checking bench for the genset mode sequencer.
   Assumes the checker is bound and timers are shortened over the register port. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
	import genset_pkg::*;
	localparam int FUEL = 10, PREHEAT = 9, CRANK = 8, IDLE = 7, SOL = 6, MC = 5, GC = 4, FTS = 0;
	localparam int B_STOP = 17, B_AUTO = 16, B_MAN = 15, B_RUN = 14, B_MC = 13, B_GC = 12;
	localparam int B_LOCK = 11, B_SIM = 10, B_FORCE = 9, B_MIL = 6, B_SPD = 0;
	logic         ref_clk = 1'b0;
	logic         reset = 1'b1;
	pins_t        tb_p = 18'h00060;
	pins_t        pins_s;
	engine_rate_t rate = '0;
	logic [7:0]   addr = 8'h00;
	logic [31:0]  wdata = 32'h00000000;
	logic         we = 1'b0;
	logic         re = 1'b0;
	logic [31:0]  rdata;
	relays_t      relays;
	logic [10:0]  rl;
	logic         fired, gok, rdone, bsync;
	logic [31:0]  d;
	int           miscompares = 0;
	int           tests_run = 0;
	always #10 ref_clk = ~ref_clk;
	assign rl = relays;
	always_comb begin
		pins_s = tb_p;
		pins_s.engine_fired = fired;
		pins_s.gen_ok = gok;
		pins_s.ramp_done = rdone;
		pins_s.busbar_synced = bsync;
	end
	genset_mode_sequencer #(.TICK_CYCLES(4)) u_genset_mode_sequencer (.ref_clk(ref_clk), .reset(reset),
		.pins(pins_s), .engine_rate(rate), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
		.relays(relays));
	engine_model u_engine_model (.ref_clk(ref_clk), .reset(reset), .relays(relays), .engine_fired(fired),
		.gen_ok(gok), .ramp_done(rdone), .busbar_synced(bsync));
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		addr <= a;
		wdata <= v;
		we <= 1'b1;
		@(posedge ref_clk);
		we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		addr <= a;
		re <= 1'b1;
		@(posedge ref_clk);
		re <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic set_pin(input int i, input logic v);
		@(posedge ref_clk);
		tb_p[i] <= v;
	endtask : set_pin
	// Held long enough to pass the input filter
	task automatic press(input int i);
		set_pin(i, 1'b1);
		repeat (8) @(posedge ref_clk);
		set_pin(i, 1'b0);
		repeat (8) @(posedge ref_clk);
	endtask : press
	task automatic wait_bit(input int i, input logic v);
		int n;
		#1 n = 0;
		while (rl[i] !== v && n < 3000) begin
			@(posedge ref_clk);
			#1 n++;
		end
		`CHK(rl[i], v)
	endtask : wait_bit
	task automatic t_regs;
		rd(A_PPV); `CHK(d, 32'h000003E8)
		rd(A_ATTEMPTS); `CHK(d, 32'h00000003)
		rd(A_TMR_BASE); `CHK(d, 32'h00000BB8)
		rd(8'hFC); `CHK(d, 32'h00000000)
		wr(A_PPV, 32'h00011170);
		rd(A_PPV); `CHK(d, 32'h0000FDE8)
		// Crank window long enough for the engine model to fire
		for (int i = 0; i < N_TMR; i++) wr(A_TMR_BASE + 8'(4 * i), (i == T_CRANK) ? 32'h00000008 : 32'h00000002);
	endtask : t_regs
	task automatic t_fuel;
		wr(A_CTRL, 32'h00000001);
		wr(A_PPV, 32'h00000003);
		for (int i = 0; i < 9; i++) begin
			if (i == 6) wr(A_CTRL, 32'h00000003);
			press(B_SPD);
		end
		rd(A_FILL); `CHK(d, 32'h00000002)
		rd(A_CONS); `CHK(d, 32'h00000001)
		@(posedge ref_clk);
		rate <= '{1'b1, 16'h1234};
		rd(A_CONS); `CHK(d, 32'h00001234)
		rate <= '0;
		wr(A_CTRL, 32'h00000000);
	endtask : t_fuel
	task automatic t_avail;
		logic [3:0] tbl [5] = '{4'b1001, 4'b0000, 4'b0101, 4'b1010, 4'b0110};
		foreach (tbl[k]) begin
			set_pin(B_MIL, tbl[k][3]);
			set_pin(B_SIM, tbl[k][2]);
			set_pin(B_FORCE, tbl[k][1]);
			repeat (10) @(posedge ref_clk);
			rd(A_STATUS); `CHK(d[31], tbl[k][0])
		end
		set_pin(B_MIL, 1'b1);
		set_pin(B_SIM, 1'b0);
		repeat (100) @(posedge ref_clk);
		`CHK(rl[FUEL], 1'b0)
		set_pin(B_FORCE, 1'b0);
		set_pin(B_LOCK, 1'b1);
		press(B_AUTO);
		rd(A_STATUS); `CHK(d[9:8], 2'h0)
		set_pin(B_LOCK, 1'b0);
	endtask : t_avail
	task automatic t_manual;
		press(B_MAN);
		press(B_RUN);
		rd(A_STATUS); `CHK(d[9:8], 2'h2)
		wait_bit(FUEL, 1'b1);
		wait_bit(CRANK, 1'b1);
		wait_bit(CRANK, 1'b0);
		wait_bit(IDLE, 1'b1);
		wait_bit(IDLE, 1'b0);
		repeat (40) @(posedge ref_clk);
		rd(A_STATUS); `CHK(d[3:0], 4'hD)
		press(B_GC);
		wait_bit(GC, 1'b1);
		press(B_MC);
		wait_bit(GC, 1'b0);
		wait_bit(MC, 1'b1);
		press(B_MC);
		wait_bit(MC, 1'b0);
		press(B_STOP);
		wait_bit(FUEL, 1'b0);
		repeat (80) @(posedge ref_clk);
		`CHK(rl[FTS], 1'b0)
		rd(A_STATUS); `CHK(d[3:0], 4'h0)
	endtask : t_manual
	// Speed pulses in stop mode stand for an engine that will not stop
	task automatic t_stall;
		for (int i = 0; i < 12; i++) begin
			set_pin(B_SPD, 1'b1);
			@(posedge ref_clk);
			set_pin(B_SPD, 1'b0);
			@(posedge ref_clk);
		end
		`CHK(rl[FTS], 1'b1)
		repeat (20) @(posedge ref_clk);
		`CHK(rl[FTS], 1'b0)
	endtask : t_stall
	task automatic t_auto;
		press(B_AUTO);
		rd(A_STATUS); `CHK(d[9:8], 2'h1)
		set_pin(B_MIL, 1'b0);
		repeat (4) @(posedge ref_clk);
		set_pin(B_MIL, 1'b1);
		repeat (60) @(posedge ref_clk);
		rd(A_STATUS); `CHK(d[3:0], 4'h0)
		set_pin(B_MIL, 1'b0);
		wait_bit(FUEL, 1'b1);
		wait_bit(PREHEAT, 1'b1);
		wait_bit(CRANK, 1'b1);
		wait_bit(IDLE, 1'b1);
		wait_bit(GC, 1'b1);
		`CHK(rl[MC], 1'b0)
		set_pin(B_MIL, 1'b1);
		wait_bit(GC, 1'b0);
		wait_bit(MC, 1'b1);
		wait_bit(SOL, 1'b1);
		`CHK(rl[FUEL], 1'b0)
		wait_bit(SOL, 1'b0);
		rd(A_STATUS); `CHK(d[3:0], 4'h0)
	endtask : t_auto
	task automatic complete_run;
		if (miscompares == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run
	// Whole run is far below this; a stuck wait ends here
	initial begin
		repeat (60000) @(posedge ref_clk);
		miscompares++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		t_regs();
		t_fuel();
		t_avail();
		t_manual();
		t_stall();
		t_auto();
		complete_run();
	end
endmodule : testbench
`default_nettype wire
